// ### pkg/spfp_pkg.sv
// Constants shared by the speech parameter frame packer and unpacker.
package spfp_pkg;

  // Frame size and short-term filter field layout (frame bit n sits at
  // vector index n-1).
  localparam int FRAME_BITS = 260;
  localparam int NUM_LAR    = 8;
  localparam int LAR_MAX_W  = 6;
  localparam int LAR_BITS   = 36;
  localparam int LAR_W   [NUM_LAR] = '{6, 6, 5, 5, 4, 4, 3, 3};
  localparam int LAR_POS [NUM_LAR] = '{0, 6, 12, 17, 22, 26, 30, 33};

  // Sub-frame group layout, offsets relative to the group start.
  localparam int NUM_SUB   = 4;
  localparam int SUB_BITS  = 56;
  localparam int NUM_PULSE = 13;
  localparam int LAG_W     = 7;
  localparam int GAIN_W    = 2;
  localparam int GRID_W    = 2;
  localparam int AMP_W     = 6;
  localparam int PULSE_W   = 3;
  localparam int LAG_OFS   = 0;
  localparam int GAIN_OFS  = 7;
  localparam int GRID_OFS  = 9;
  localparam int AMP_OFS   = 11;
  localparam int PULSE_OFS = 17;

  // Valid range of the lag value.
  localparam logic [LAG_W-1:0] LAG_MIN = 7'h28;
  localparam logic [LAG_W-1:0] LAG_MAX = 7'h78;

  // Frame timing: 160 samples at 8 kHz on a 40 MHz clock.
  localparam int CLK_HZ            = 40000000;
  localparam int SAMPLE_RATE_HZ    = 8000;
  localparam int SAMPLES_PER_FRAME = 160;
  localparam int FRAME_CYCLES_DFLT =
    (CLK_HZ / SAMPLE_RATE_HZ) * SAMPLES_PER_FRAME;
  localparam int CNT_W             = 20;

  // Transcoder delay budget in ms; packing adds one clock cycle.
  localparam int DELAY_MIN_MS = 20;
  localparam int DELAY_MAX_MS = 30;
  localparam int PACK_LAT     = 1;

endpackage : spfp_pkg

// ### pkg/spfp_param_if.sv
// Parameter set of one speech frame, carried between the framer modules.
`timescale 1ns/1ps
`default_nettype none
interface spfp_param_if;
  import spfp_pkg::*;

  // One field per parameter, in frame order; nets, since the unpacker
  // drives them one field at a time.
  wire logic [NUM_LAR-1:0][LAR_MAX_W-1:0]              log_area_ratio_field;
  wire logic [NUM_SUB-1:0][LAG_W-1:0]                  lag;
  wire logic [NUM_SUB-1:0][GAIN_W-1:0]                 gain;
  wire logic [NUM_SUB-1:0][GRID_W-1:0]                 grid;
  wire logic [NUM_SUB-1:0][AMP_W-1:0]                  amp;
  wire logic [NUM_SUB-1:0][NUM_PULSE-1:0][PULSE_W-1:0] pulse;

  modport src (output log_area_ratio_field, output lag, output gain, output grid,
               output amp, output pulse);
  modport snk (input log_area_ratio_field, input lag, input gain, input grid,
               input amp, input pulse);
endinterface : spfp_param_if
`default_nettype wire

// ### design/spfp_packer.sv
// Maps one parameter set onto the 260-bit frame vector.
`timescale 1ns/1ps
`default_nettype none
module spfp_packer
  import spfp_pkg::*;
(
  spfp_param_if.snk              prm,
  output wire logic [FRAME_BITS-1:0] frame
);

  // Short-term filter fields first, LSB at the lowest frame bit.
  for (genvar i = 0; i < NUM_LAR; i++) begin : g_lar
    assign frame[LAR_POS[i] +: LAR_W[i]] = prm.log_area_ratio_field[i][LAR_W[i]-1:0];
  end

  // Four sub-frame groups: lag, gain, grid, amplitude, then pulses.
  for (genvar j = 0; j < NUM_SUB; j++) begin : g_sub
    localparam int BASE = LAR_BITS + j * SUB_BITS;
    assign frame[BASE + LAG_OFS  +: LAG_W]  = prm.lag[j];
    assign frame[BASE + GAIN_OFS +: GAIN_W] = prm.gain[j];
    assign frame[BASE + GRID_OFS +: GRID_W] = prm.grid[j];
    assign frame[BASE + AMP_OFS  +: AMP_W]  = prm.amp[j];
    for (genvar k = 0; k < NUM_PULSE; k++) begin : g_pulse
      localparam int POS = BASE + PULSE_OFS + k * PULSE_W;
      assign frame[POS +: PULSE_W] = prm.pulse[j][k];
    end
  end

endmodule : spfp_packer
`default_nettype wire

// ### design/spfp_unpacker.sv
// Extracts the parameter set from a 260-bit frame vector.
`timescale 1ns/1ps
`default_nettype none
module spfp_unpacker
  import spfp_pkg::*;
(
  input  wire logic [FRAME_BITS-1:0] frame,
  spfp_param_if.src                  prm
);

  // Same positions as the packer; narrow fields are zero-extended.
  for (genvar i = 0; i < NUM_LAR; i++) begin : g_lar
    assign prm.log_area_ratio_field[i] = LAR_MAX_W'(frame[LAR_POS[i] +: LAR_W[i]]);
  end

  // Sub-frame groups in the packer's order and format.
  for (genvar j = 0; j < NUM_SUB; j++) begin : g_sub
    localparam int BASE = LAR_BITS + j * SUB_BITS;
    assign prm.lag[j]  = frame[BASE + LAG_OFS  +: LAG_W];
    assign prm.gain[j] = frame[BASE + GAIN_OFS +: GAIN_W];
    assign prm.grid[j] = frame[BASE + GRID_OFS +: GRID_W];
    assign prm.amp[j]  = frame[BASE + AMP_OFS  +: AMP_W];
    for (genvar k = 0; k < NUM_PULSE; k++) begin : g_pulse
      localparam int POS = BASE + PULSE_OFS + k * PULSE_W;
      assign prm.pulse[j][k] = frame[POS +: PULSE_W];
    end
  end

endmodule : spfp_unpacker
`default_nettype wire

// ### design/spfp_top.sv
// Speech parameter frame packer and unpacker with frame-rate pacing.
`timescale 1ns/1ps
`default_nettype none
module spfp_top
  import spfp_pkg::*;
#(
  parameter int unsigned FRAME_CYCLES = FRAME_CYCLES_DFLT
) (
  input  wire logic                                   clk,
  input  wire logic                                   rst_n,
  // Encoder parameter side.
  input  wire logic                                   enc_valid,
  output logic                                        enc_ready,
  input  wire logic [NUM_LAR-1:0][LAR_MAX_W-1:0]      enc_lar,
  input  wire logic [NUM_SUB-1:0][LAG_W-1:0]          enc_lag,
  input  wire logic [NUM_SUB-1:0][GAIN_W-1:0]         enc_gain,
  input  wire logic [NUM_SUB-1:0][GRID_W-1:0]         enc_grid,
  input  wire logic [NUM_SUB-1:0][AMP_W-1:0]          enc_amp,
  input  wire logic [NUM_SUB-1:0][NUM_PULSE-1:0][PULSE_W-1:0] enc_pulse,
  // Packed frame toward channel coding.
  output logic [FRAME_BITS-1:0]                       frame_data,
  output logic                                        frame_valid,
  output logic                                        frame_lag_err,
  output logic                                        frame_missed,
  // Received frame from channel decoding.
  input  wire logic [FRAME_BITS-1:0]                  rx_frame,
  input  wire logic                                   rx_valid,
  // Unpacked parameters toward the speech decoder.
  output logic                                        dec_valid,
  output logic                                        dec_lag_err,
  output logic [NUM_LAR-1:0][LAR_MAX_W-1:0]           dec_lar,
  output logic [NUM_SUB-1:0][LAG_W-1:0]               dec_lag,
  output logic [NUM_SUB-1:0][GAIN_W-1:0]              dec_gain,
  output logic [NUM_SUB-1:0][GRID_W-1:0]              dec_grid,
  output logic [NUM_SUB-1:0][AMP_W-1:0]               dec_amp,
  output logic [NUM_SUB-1:0][NUM_PULSE-1:0][PULSE_W-1:0] dec_pulse
);

  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(FRAME_CYCLES - 1);

  spfp_param_if enc_if ();
  spfp_param_if dec_if ();

  logic [FRAME_BITS-1:0] packed_frame;
  logic [CNT_W-1:0]      period_cnt_q;
  logic                  period_end;
  logic                  slot_open_q;
  logic                  accept;
  logic                  enc_lag_bad;
  logic                  rx_lag_bad;
  logic [FRAME_BITS-1:0] frame_data_q;
  logic                  frame_valid_q;
  logic                  frame_lag_err_q;
  logic                  frame_missed_q;
  logic                  dec_valid_q;
  logic                  dec_lag_err_q;
  logic [NUM_LAR-1:0][LAR_MAX_W-1:0]              dec_lar_q;
  logic [NUM_SUB-1:0][LAG_W-1:0]                  dec_lag_q;
  logic [NUM_SUB-1:0][GAIN_W-1:0]                 dec_gain_q;
  logic [NUM_SUB-1:0][GRID_W-1:0]                 dec_grid_q;
  logic [NUM_SUB-1:0][AMP_W-1:0]                  dec_amp_q;
  logic [NUM_SUB-1:0][NUM_PULSE-1:0][PULSE_W-1:0] dec_pulse_q;

  // Encoder ports feed the packer through the parameter carrier.
  assign enc_if.log_area_ratio_field   = enc_lar;
  assign enc_if.lag   = enc_lag;
  assign enc_if.gain  = enc_gain;
  assign enc_if.grid  = enc_grid;
  assign enc_if.amp   = enc_amp;
  assign enc_if.pulse = enc_pulse;

  spfp_packer u_packer (
    .prm   (enc_if),
    .frame (packed_frame)
  );

  spfp_unpacker u_unpacker (
    .frame (rx_frame),
    .prm   (dec_if)
  );

  // Lag range checks on both sides; the value itself passes untouched.
  always_comb begin
    enc_lag_bad = 1'b0;
    rx_lag_bad  = 1'b0;
    for (int j = 0; j < NUM_SUB; j++) begin
      if (enc_lag[j] < LAG_MIN || enc_lag[j] > LAG_MAX) begin
        enc_lag_bad = 1'b1;
      end
      if (dec_if.lag[j] < LAG_MIN || dec_if.lag[j] > LAG_MAX) begin
        rx_lag_bad = 1'b1;
      end
    end
  end

  // Frame period counter: one slot per 160-sample period.
  assign period_end = (period_cnt_q == CNT_LAST);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      period_cnt_q <= '0;
    end else if (period_end) begin
      period_cnt_q <= '0;
    end else begin
      period_cnt_q <= period_cnt_q + CNT_W'(1);
    end
  end

  // The slot opens at each period start and closes on acceptance; a new
  // period opening in the same cycle as an accept wins.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      slot_open_q <= 1'b1;
    end else if (period_end) begin
      slot_open_q <= 1'b1;
    end else if (accept) begin
      slot_open_q <= 1'b0;
    end
  end

  assign enc_ready = slot_open_q;
  assign accept    = enc_valid && slot_open_q;

  // Packed frame register, loaded in the accept cycle.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      frame_data_q <= '0;
    end else if (accept) begin
      frame_data_q <= packed_frame;
    end
  end

  // Single-cycle frame strobe with its lag range flag.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      frame_valid_q   <= 1'b0;
      frame_lag_err_q <= 1'b0;
    end else begin
      frame_valid_q   <= accept;
      frame_lag_err_q <= accept && enc_lag_bad;
    end
  end

  // Flags a period that ended without any parameter set delivered.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      frame_missed_q <= 1'b0;
    end else begin
      frame_missed_q <= period_end && slot_open_q && !accept;
    end
  end

  // Unpacked parameters are captured on each received frame.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dec_lar_q   <= '0;
      dec_lag_q   <= '0;
      dec_gain_q  <= '0;
      dec_grid_q  <= '0;
      dec_amp_q   <= '0;
      dec_pulse_q <= '0;
    end else if (rx_valid) begin
      dec_lar_q   <= dec_if.log_area_ratio_field;
      dec_lag_q   <= dec_if.lag;
      dec_gain_q  <= dec_if.gain;
      dec_grid_q  <= dec_if.grid;
      dec_amp_q   <= dec_if.amp;
      dec_pulse_q <= dec_if.pulse;
    end
  end

  // Decode strobe follows the received frame by one cycle.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dec_valid_q   <= 1'b0;
      dec_lag_err_q <= 1'b0;
    end else begin
      dec_valid_q   <= rx_valid;
      dec_lag_err_q <= rx_valid && rx_lag_bad;
    end
  end

  // Output assignments from the registers.
  assign frame_data    = frame_data_q;
  assign frame_valid   = frame_valid_q;
  assign frame_lag_err = frame_lag_err_q;
  assign frame_missed  = frame_missed_q;
  assign dec_valid     = dec_valid_q;
  assign dec_lag_err   = dec_lag_err_q;
  assign dec_lar       = dec_lar_q;
  assign dec_lag       = dec_lag_q;
  assign dec_gain      = dec_gain_q;
  assign dec_grid      = dec_grid_q;
  assign dec_amp       = dec_amp_q;
  assign dec_pulse     = dec_pulse_q;

  // Checks on the design's own outputs.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  localparam int S2 = LAR_BITS + SUB_BITS;
  localparam int S4 = LAR_BITS + 3 * SUB_BITS;
  localparam int P12 = PULSE_OFS + (NUM_PULSE - 1) * PULSE_W;

  // Accepts seen in the current period, read only by a check.
  logic [1:0] acc_in_period_q;
  always_ff @(posedge clk) begin
    if (!rst_n || period_end) begin
      acc_in_period_q <= 2'h0;
    end else if (accept && acc_in_period_q != 2'h3) begin
      acc_in_period_q <= acc_in_period_q + 2'h1;
    end
  end

  sequence acc_s;
    enc_valid && enc_ready;
  endsequence

  // The strobe drops after one cycle unless a new accept follows at once,
  // which a wrap in the same cycle as an accept allows.
  sequence strobe_s;
    frame_valid ##1 (!frame_valid || $past(accept));
  endsequence

  sequence rx_s;
    rx_valid;
  endsequence

  pack_latency_a: assert property (acc_s |=> strobe_s)
    else $error("frame strobe missing one cycle after accept");
  strobe_cause_a: assert property (frame_valid |-> $past(accept))
    else $error("frame strobe without an accepted set");
  ratio_place_a: assert property (frame_valid |->
      frame_data[LAR_POS[0] +: LAR_W[0]] == $past(enc_lar[0])
      && frame_data[LAR_POS[7] +: LAR_W[7]] ==
         $past(enc_lar[7][LAR_W[7]-1:0]))
    else $error("ratio field misplaced");
  lag_place_a: assert property (frame_valid |->
      frame_data[S2 + LAG_OFS +: LAG_W] == $past(enc_lag[1]))
    else $error("second group lag misplaced");
  gain_grid_a: assert property (frame_valid |->
      frame_data[S2 + GAIN_OFS +: GAIN_W] == $past(enc_gain[1])
      && frame_data[S2 + GRID_OFS +: GRID_W] ==
         $past(enc_grid[1]))
    else $error("second group gain or grid misplaced");
  amp_place_a: assert property (frame_valid |->
      frame_data[S2 + AMP_OFS +: AMP_W] == $past(enc_amp[1]))
    else $error("second group amplitude misplaced");
  pulse_place_a: assert property (frame_valid |->
      frame_data[S2 + P12 +: PULSE_W] == $past(enc_pulse[1][12])
      && frame_data[S4 + P12 +: PULSE_W] ==
         $past(enc_pulse[3][12]))
    else $error("last pulse code misplaced");
  frame_hold_a: assert property (frame_valid ##1 !accept[*2] |->
      $stable(frame_data))
    else $error("frame data changed without an accept");
  one_per_period_a: assert property (acc_in_period_q <= 2'h1)
    else $error("more than one set accepted in a period");
  unpack_match_a: assert property (rx_s |=> dec_valid
      && dec_lag[1] == $past(rx_frame[S2 + LAG_OFS +: LAG_W])
      && dec_pulse[3][12] == $past(rx_frame[S4 + P12 +: PULSE_W])
      && dec_lar[2] == LAR_MAX_W'($past(
         rx_frame[LAR_POS[2] +: LAR_W[2]])))
    else $error("unpacked field does not match frame");
  lag_range_a: assert property (acc_s |=>
      frame_lag_err == (frame_data[LAR_BITS + LAG_OFS +: LAG_W] < LAG_MIN
      || frame_data[LAR_BITS + LAG_OFS +: LAG_W] > LAG_MAX
      || $past(enc_lag_bad)))
    else $error("lag range flag wrong");

endmodule : spfp_top
`default_nettype wire

// ### dv/spfp_enc_model.sv
// Encoder-side partner that offers parameter sets over valid/ready.
`timescale 1ns/1ps
`default_nettype none
module spfp_enc_model (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         offer,
  input  wire logic [271:0] nxt,
  input  wire logic         enc_ready,
  output logic              enc_valid,
  output logic [271:0]      cur,
  output logic              taken
);
  // A set is taken at an edge where both handshake lines are high.
  assign taken = enc_valid && enc_ready;

  // Hold a set until taken; between offers the lines keep changing.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      enc_valid <= 1'b0;
      cur       <= '0;
    end else if (taken) begin
      enc_valid <= 1'b0;
      cur       <= ~cur;
    end else if (!enc_valid) begin
      enc_valid <= offer;
      cur       <= offer ? nxt : ~cur;
    end
  end
endmodule : spfp_enc_model
`default_nettype wire

// ### dv/tb_speech_param_frame_packer.sv
// Self-checking bench for the speech parameter frame packer.
`timescale 1ns/1ps
`default_nettype none
module tb_speech_param_frame_packer;
  import spfp_pkg::*;
  localparam int FC = 16;
  localparam int LW [8] = '{6, 6, 5, 5, 4, 4, 3, 3};
  logic clk, rst_n, offer, enc_valid, enc_ready, taken, lb;
  logic frame_valid, frame_lag_err, frame_missed, rx_valid;
  logic dec_valid, dec_lag_err, pend, rxp, slot, miss_e, exp_le;
  logic [271:0] nxt, cur, rs, acc_set, rx_e, v;
  logic [259:0] frame_data, rx_frame, exp_f;
  wire logic [271:0] dec_set;
  int cnt, fails, n_compared, seed;

  // Frame layout worked out from the field widths in frame order.
  function automatic logic [259:0] pack_f(input logic [271:0] s);
    logic [259:0] f;
    int p, w, src;
    f = '0;
    p = 0;
    for (int i = 0; i < 8; i++) begin
      for (int b = 0; b < LW[i]; b++) f[p+b] = s[224+6*i+b];
      p += LW[i];
    end
    for (int j = 0; j < 4; j++) begin
      for (int k = 0; k < 17; k++) begin
        w = (k == 0) ? 7 : (k < 3) ? 2 : (k == 3) ? 6 : 3;
        src = (k == 0) ? 196 + 7*j : (k == 1) ? 188 + 2*j :
              (k == 2) ? 180 + 2*j : (k == 3) ? 156 + 6*j : 39*j + 3*(k-4);
        for (int b = 0; b < w; b++) f[p+b] = s[src+b];
        p += w;
      end
    end
    return f;
  endfunction : pack_f

  // High when any lag lies outside 40..120.
  function automatic logic lerr(input logic [271:0] s);
    logic e;
    e = 1'b0;
    for (int j = 0; j < 4; j++)
      if (s[196+7*j+:7] < 7'h28 || s[196+7*j+:7] > 7'h78) e = 1'b1;
    return e;
  endfunction : lerr

  // Ratio bits above each field width do not travel in the frame.
  function automatic logic [271:0] mask(input logic [271:0] s);
    for (int i = 0; i < 8; i++)
      for (int b = LW[i]; b < 6; b++) s[224+6*i+b] = 1'b0;
    return s;
  endfunction : mask

  task automatic check(input string nm, input logic [271:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test

  task automatic rnd(output logic [271:0] r);
    r = '0;
    for (int i = 0; i < 9; i++) r = {r[239:0], 32'($random(seed))};
  endtask : rnd

  // Offer one set and wait, bounded, until the packer takes it.
  task automatic offer_set(input logic [271:0] s);
    int t;
    nxt <= s;
    offer <= 1'b1;
    t = 0;
    // The model latches the offer at the next edge and holds it until taken.
    @(posedge clk);
    offer <= 1'b0;
    do begin
      @(posedge clk);
      t++;
    end while (!taken && t < 4 * FC);
    if (!taken) begin
      check("enc_handshake", 1'b0, 1'b1);
      finish_test();
    end
  endtask : offer_set

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  spfp_enc_model u_enc (.clk(clk), .rst_n(rst_n), .offer(offer), .nxt(nxt),
    .enc_ready(enc_ready), .enc_valid(enc_valid), .cur(cur), .taken(taken));

  spfp_top #(.FRAME_CYCLES(FC)) dut (.clk(clk), .rst_n(rst_n),
    .enc_valid(enc_valid), .enc_ready(enc_ready),
    .enc_lar(cur[271:224]), .enc_lag(cur[223:196]),
    .enc_gain(cur[195:188]), .enc_grid(cur[187:180]),
    .enc_amp(cur[179:156]), .enc_pulse(cur[155:0]),
    .frame_data(frame_data), .frame_valid(frame_valid),
    .frame_lag_err(frame_lag_err), .frame_missed(frame_missed),
    .rx_frame(rx_frame), .rx_valid(rx_valid), .dec_valid(dec_valid),
    .dec_lag_err(dec_lag_err), .dec_lar(dec_set[271:224]),
    .dec_lag(dec_set[223:196]), .dec_gain(dec_set[195:188]),
    .dec_grid(dec_set[187:180]), .dec_amp(dec_set[179:156]),
    .dec_pulse(dec_set[155:0]));

  // Channel coding reorders and restores the bits, so the loop is in order.
  always @(posedge clk) begin
    if (lb) begin
      rx_valid <= frame_valid;
      rx_frame <= frame_valid ? frame_data : ~rx_frame;
    end
  end

  // Reference model of pacing, packing and unpacking, checked every cycle.
  always @(posedge clk) begin
    if (!rst_n) begin
      pend <= 1'b0;
      rxp <= 1'b0;
      slot <= 1'b1;
      miss_e <= 1'b0;
      cnt <= 0;
    end else begin
      check("enc_ready", enc_ready, slot);
      check("frame_valid", frame_valid, pend);
      check("frame_missed", frame_missed, miss_e);
      if (pend) begin
        check("frame_data", frame_data, exp_f);
        check("frame_lag_err", frame_lag_err, exp_le);
      end
      check("dec_valid", dec_valid, rxp);
      if (rxp) begin
        check("dec_set", dec_set, mask(rx_e));
        check("dec_lag_err", dec_lag_err, lerr(rx_e));
      end
      pend <= taken;
      exp_f <= pack_f(cur);
      exp_le <= lerr(cur);
      if (taken) acc_set <= cur;
      miss_e <= (cnt == FC - 1) && slot && !taken;
      slot <= (cnt == FC - 1) ? 1'b1 : (taken ? 1'b0 : slot);
      cnt <= (cnt == FC - 1) ? 0 : cnt + 1;
      rxp <= rx_valid;
      rx_e <= lb ? acc_set : rs;
    end
  end

  initial begin
    int sp [7] = '{224, 266, 203, 190, 182, 162, 75};
    int sw [7] = '{6, 6, 7, 2, 2, 6, 3};
    int fp [7] = '{0, 33, 92, 99, 101, 103, 145};
    int fw [7] = '{6, 3, 7, 2, 2, 6, 3};
    rst_n = 1'b0;
    offer = 1'b0;
    nxt = '0;
    rs = '0;
    acc_set = '0;
    rx_frame = '0;
    rx_valid = 1'b0;
    lb = 1'b1;
    seed = 51615;
    fails = 0;
    n_compared = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1 check("frame_data_rst", frame_data, '0);
    check("dec_set_rst", dec_set, '0);
    // One field at a time lands on its own frame bits.
    for (int c = 0; c < 7; c++) begin
      offer_set(((272'h1 << sw[c]) - 1) << sp[c]);
      @(posedge clk);
      #1 check("frame_pos", frame_data, ((260'h1 << fw[c]) - 1) << fp[c]);
    end
    v = '0;
    v[196+:28] = {7'h79, 7'h78, 7'h28, 7'h27};
    offer_set(v);
    v[196+:28] = {7'h78, 7'h28, 7'h78, 7'h28};
    offer_set(v);
    // Random sets, with a pause now and then that delays the next set a few cycles into its period.
    for (int n = 0; n < 12; n++) begin
      rnd(v);
      offer_set(v);
      if (n % 4 == 3) repeat (FC + 2) @(posedge clk);
    end
    repeat (6) @(posedge clk);
    lb <= 1'b0;
    @(posedge clk);
    // Received frames back to back, with random gaps.
    for (int n = 0; n < 24; n++) begin
      rnd(v);
      rs <= v;
      rx_frame <= pack_f(v);
      rx_valid <= ($random(seed) & 3) != 0;
      @(posedge clk);
    end
    rx_valid <= 1'b0;
    repeat (3) @(posedge clk);
    finish_test();
  end
endmodule : tb_speech_param_frame_packer
`default_nettype wire
